// ==== verilog/bmq_pkg.sv ====
// Constants and types of the boot-mode query command block
package bmq_pkg;
  localparam logic [7:0]  BMQ_CMD_SUM_UA  = 8'h4B;
  localparam logic [7:0]  BMQ_CMD_BLK_UB  = 8'h4C;
  localparam logic [7:0]  BMQ_CMD_BLK_UA  = 8'h4D;
  localparam logic [7:0]  BMQ_CMD_INQ     = 8'h4F;
  localparam logic [7:0]  BMQ_RSP_SUM_UA  = 8'h5B;
  localparam logic [7:0]  BMQ_RSP_INQ     = 8'h5F;
  localparam logic [7:0]  BMQ_RSP_ACK     = 8'h06;
  localparam logic [7:0]  BMQ_RSP_BLK_UB  = 8'hCC;
  localparam logic [7:0]  BMQ_RSP_BLK_UA  = 8'hCD;
  localparam logic [7:0]  BMQ_RSP_ERR_BIT = 8'h80;
  localparam logic [7:0]  BMQ_SIZE_SUM    = 8'h04;
  localparam logic [7:0]  BMQ_SIZE_INQ    = 8'h02;
  localparam logic [7:0]  BMQ_ERASED      = 8'hFF;
  // Status codes
  localparam logic [7:0]  BMQ_ST_DEV_WAIT = 8'h11;
  localparam logic [7:0]  BMQ_ST_CLK_WAIT = 8'h12;
  localparam logic [7:0]  BMQ_ST_BR_WAIT  = 8'h13;
  localparam logic [7:0]  BMQ_ST_PE_TRANS = 8'h1F;
  localparam logic [7:0]  BMQ_ST_PE       = 8'h31;
  localparam logic [7:0]  BMQ_ST_SEL_WAIT = 8'h3F;
  localparam logic [7:0]  BMQ_ST_PGM_WAIT = 8'h4F;
  localparam logic [7:0]  BMQ_ST_BLK_WAIT = 8'h5F;
  // Error codes
  localparam logic [7:0]  BMQ_E_NONE      = 8'h00;
  localparam logic [7:0]  BMQ_E_CKSUM     = 8'h11;
  localparam logic [7:0]  BMQ_E_PSIZE     = 8'h12;
  localparam logic [7:0]  BMQ_E_DEVICE    = 8'h21;
  localparam logic [7:0]  BMQ_E_CLKMODE   = 8'h22;
  localparam logic [7:0]  BMQ_E_BITRATE   = 8'h24;
  localparam logic [7:0]  BMQ_E_INFREQ    = 8'h25;
  localparam logic [7:0]  BMQ_E_DIVRATIO  = 8'h26;
  localparam logic [7:0]  BMQ_E_OPFREQ    = 8'h27;
  localparam logic [7:0]  BMQ_E_BLOCK     = 8'h29;
  localparam logic [7:0]  BMQ_E_ADDRESS   = 8'h2A;
  localparam logic [7:0]  BMQ_E_DLEN      = 8'h2B;
  localparam logic [7:0]  BMQ_E_ERASING   = 8'h51;
  localparam logic [7:0]  BMQ_E_ERASE_INC = 8'h52;
  localparam logic [7:0]  BMQ_E_PROGRAM   = 8'h53;
  localparam logic [7:0]  BMQ_E_SELPROC   = 8'h54;
  localparam logic [7:0]  BMQ_E_COMMAND   = 8'h80;
  localparam logic [7:0]  BMQ_E_BR_CONF   = 8'hFF;
  // Area geometry, key area, inquiry threshold and buffer size
  localparam logic [19:0] BMQ_UA_SIZE     = 20'h80000;
  localparam logic [19:0] BMQ_UB_SIZE     = 20'h04000;
  localparam logic [19:0] BMQ_KEY_BASE    = 20'h0003C;
  localparam logic [19:0] BMQ_KEY_LAST    = 20'h00003;
  localparam logic [2:0]  BMQ_INQ_FIRST   = 3'h3;
  localparam int          BMQ_FIFO_DEPTH  = 8;
  localparam int          BMQ_FIFO_WIDTH  = 8;

  typedef enum logic [1:0] {BMQ_KEY, BMQ_IDLE, BMQ_SCAN, BMQ_SEND} bmq_state_e;

  typedef struct packed {
    bmq_state_e      st;
    logic [19:0]     cnt;
    logic [31:0]     sum;
    logic            blank;
    logic            area;
    logic [7:0]      cmd;
    logic [6:0][7:0] frm;
    logic [2:0]      len;
    logic [2:0]      idx;
    logic            err_flag;
    logic            key_bad;
    logic [7:0]      pm_data;
  } bmq_core_s;
endpackage

// ==== verilog/bmq_fifo.sv ====
// Byte FIFO between the reply builder and the serial transmitter
`timescale 1ns/10ps
`default_nettype none
module bmq_fifo
  import bmq_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wr;
    logic [AW-1:0]       rd;
    logic [AW:0]         cnt;
  } bmq_fifo_s;

  bmq_fifo_s q_r;
  bmq_fifo_s q_nxt;
  logic      push;
  logic      pop;

  assign in_ready  = (q_r.cnt != (AW+1)'(D));
  assign out_valid = (q_r.cnt != '0);
  assign out_data  = q_r.mem[q_r.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wr] = in_data;
      q_nxt.wr = (q_r.wr == AW'(D-1)) ? '0 : q_r.wr + 1'b1;
    end
    if (pop) begin
      q_nxt.rd = (q_r.rd == AW'(D-1)) ? '0 : q_r.rd + 1'b1;
    end
    q_nxt.cnt = q_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule // bmq_fifo
`default_nettype wire

// ==== verilog/bmq_core.sv ====
// Boot-mode query command interpreter: sum checks, blank checks, state inquiry
`timescale 1ns/10ps
`default_nettype none
module bmq_core
  import bmq_pkg::*;
#(
  parameter logic [19:0] UA_SIZE = BMQ_UA_SIZE,
  parameter logic [19:0] UB_SIZE = BMQ_UB_SIZE
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  output logic [19:0]      flash_addr,
  output logic             flash_area,
  input  wire logic [7:0]  flash_rdata,
  input  wire logic [2:0]  boot_state,
  input  wire logic        err_event,
  input  wire logic        err_clear,
  input  wire logic        pm_mode,
  input  wire logic [19:0] pm_addr,
  output logic [7:0]       pm_data,
  output logic             busy
);
  bmq_core_s       q_r;
  bmq_core_s       q_nxt;
  logic            push;
  logic            fifo_ready;
  logic [7:0]      push_data;
  logic [7:0]      cmd_sel;
  logic [31:0]     sum_in;
  logic            blank_in;
  logic            inq_ok;
  logic            scan_last;
  logic [6:0][7:0] fb;
  logic [2:0]      fl;
  logic            framed;
  logic            err_set;
  logic [7:0]      ck;

  // ----------------------------------------------------------------
  // Status code of the surrounding boot sequencer
  // ----------------------------------------------------------------
  function automatic logic [7:0] status_code(input logic [2:0] s);
    case (s)
      3'h0:    status_code = BMQ_ST_DEV_WAIT;
      3'h1:    status_code = BMQ_ST_CLK_WAIT;
      3'h2:    status_code = BMQ_ST_BR_WAIT;
      3'h3:    status_code = BMQ_ST_PE_TRANS;
      3'h4:    status_code = BMQ_ST_PE;
      3'h5:    status_code = BMQ_ST_SEL_WAIT;
      3'h6:    status_code = BMQ_ST_PGM_WAIT;
      default: status_code = BMQ_ST_BLK_WAIT;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Reply frame builder
  // ----------------------------------------------------------------
  assign cmd_sel   = (q_r.st == BMQ_IDLE) ? rx_data : q_r.cmd;
  // Setup waits are not yet a selection state
  assign inq_ok    = (boot_state >= BMQ_INQ_FIRST);
  assign sum_in    = q_r.sum + {24'h0, flash_rdata};
  assign blank_in  = q_r.blank && (flash_rdata == BMQ_ERASED);
  assign scan_last = (q_r.cnt == (q_r.area ? UA_SIZE : UB_SIZE) - 20'h1);

  always_comb begin
    fb     = '0;
    fl     = 3'h2;
    framed = 1'b0;
    ck     = 8'h00;
    case (cmd_sel)
      BMQ_CMD_SUM_UA: begin
        fb[0]  = BMQ_RSP_SUM_UA;
        fb[1]  = BMQ_SIZE_SUM;
        fb[2]  = sum_in[31:24];
        fb[3]  = sum_in[23:16];
        fb[4]  = sum_in[15:8];
        fb[5]  = sum_in[7:0];
        fl     = 3'h7;
        framed = 1'b1;
      end
      BMQ_CMD_BLK_UB, BMQ_CMD_BLK_UA: begin
        if (blank_in) begin
          fb[0] = BMQ_RSP_ACK;
          fl    = 3'h1;
        end else begin
          fb[0] = (cmd_sel == BMQ_CMD_BLK_UB) ? BMQ_RSP_BLK_UB : BMQ_RSP_BLK_UA;
          fb[1] = BMQ_E_ERASE_INC;
        end
      end
      default: begin
        if (cmd_sel == BMQ_CMD_INQ && inq_ok) begin
          fb[0]  = BMQ_RSP_INQ;
          fb[1]  = BMQ_SIZE_INQ;
          fb[2]  = status_code(boot_state);
          fb[3]  = {7'h00, q_r.err_flag};
          fl     = 3'h5;
          framed = 1'b1;
        end else begin
          fb[0] = cmd_sel | BMQ_RSP_ERR_BIT;
          fb[1] = BMQ_E_COMMAND;
        end
      end
    endcase
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < fl - 3'h1) begin
        ck = ck + fb[i];
      end
    end
    // Trailing byte makes the whole frame sum to zero
    if (framed) begin
      fb[fl - 3'h1] = 8'h00 - ck;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign rx_ready  = (q_r.st == BMQ_IDLE);
  assign push      = (q_r.st == BMQ_SEND) && fifo_ready;
  assign push_data = q_r.frm[q_r.idx];
  assign busy      = (q_r.st != BMQ_IDLE);
  assign pm_data   = q_r.pm_data;

  always_comb begin
    q_nxt      = q_r;
    flash_addr = q_r.cnt;
    flash_area = q_r.area;
    err_set    = err_event;
    case (q_r.st)
      BMQ_KEY: begin
        // Key area sits in the user area, checked once after reset
        flash_addr = BMQ_KEY_BASE + q_r.cnt;
        flash_area = 1'b1;
        if (flash_rdata != BMQ_ERASED) begin
          q_nxt.key_bad = 1'b1;
        end
        q_nxt.cnt = q_r.cnt + 20'h1;
        if (q_r.cnt == BMQ_KEY_LAST) begin
          q_nxt.cnt = '0;
          q_nxt.st  = BMQ_IDLE;
        end
      end
      BMQ_IDLE: begin
        flash_addr = pm_addr;
        flash_area = 1'b1;
        if (rx_valid) begin
          q_nxt.cmd   = rx_data;
          q_nxt.cnt   = '0;
          q_nxt.sum   = '0;
          q_nxt.blank = 1'b1;
          q_nxt.idx   = '0;
          case (rx_data)
            BMQ_CMD_SUM_UA, BMQ_CMD_BLK_UA: begin
              q_nxt.area = 1'b1;
              q_nxt.st   = BMQ_SCAN;
            end
            BMQ_CMD_BLK_UB: begin
              q_nxt.area = 1'b0;
              q_nxt.st   = BMQ_SCAN;
            end
            default: begin
              q_nxt.frm = fb;
              q_nxt.len = fl;
              q_nxt.st  = BMQ_SEND;
              if (!(rx_data == BMQ_CMD_INQ && inq_ok)) begin
                err_set = 1'b1;
              end
            end
          endcase
        end
      end
      BMQ_SCAN: begin
        q_nxt.sum   = sum_in;
        q_nxt.blank = blank_in;
        q_nxt.cnt   = q_r.cnt + 20'h1;
        if (scan_last) begin
          q_nxt.frm = fb;
          q_nxt.len = fl;
          q_nxt.st  = BMQ_SEND;
          if (q_r.cmd != BMQ_CMD_SUM_UA && !blank_in) begin
            err_set = 1'b1;
          end
        end
      end
      BMQ_SEND: begin
        if (push) begin
          q_nxt.idx = q_r.idx + 3'h1;
          if (q_r.idx == q_r.len - 3'h1) begin
            q_nxt.st = BMQ_IDLE;
          end
        end
      end
      default: begin
        q_nxt.st = BMQ_IDLE;
      end
    endcase
    // A new error outranks a clear in the same cycle
    q_nxt.err_flag = (q_r.err_flag && !err_clear) || err_set;
    // Locked key area hides flash contents from the programmer
    q_nxt.pm_data = (pm_mode && !q_r.key_bad && q_r.st == BMQ_IDLE) ? flash_rdata : 8'h00;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Reply buffer
  // ----------------------------------------------------------------
  bmq_fifo #(
    .W (BMQ_FIFO_WIDTH),
    .D (BMQ_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (q_r.st == BMQ_SEND),
    .in_ready  (fifo_ready),
    .in_data   (push_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] frm_total;
  always_comb begin
    frm_total = 8'h00;
    for (int i = 0; i < 7; i++) begin
      if (3'(i) < q_r.len) begin
        frm_total = frm_total + q_r.frm[i];
      end
    end
  end

  property p_sum_frame;
    @(posedge clk) disable iff (reset)
    push && q_r.cmd == BMQ_CMD_SUM_UA && q_r.idx == 3'h0
      |-> push_data == BMQ_RSP_SUM_UA ##1 (push_data == BMQ_SIZE_SUM || !push)[*1];
  endproperty
  a_sum_frame: assert property (p_sum_frame) else $error("sum reply header wrong");

  property p_sum_add;
    @(posedge clk) disable iff (reset)
    q_r.st == BMQ_SCAN |=> q_r.sum == $past(q_r.sum) + {24'h0, $past(flash_rdata)};
  endproperty
  a_sum_add: assert property (p_sum_add) else $error("area sum not accumulated");

  property p_blank_ack;
    @(posedge clk) disable iff (reset)
    q_r.st == BMQ_SCAN && scan_last && q_r.cmd != BMQ_CMD_SUM_UA && blank_in
      |=> q_r.frm[0] == BMQ_RSP_ACK && q_r.len == 3'h1;
  endproperty
  a_blank_ack: assert property (p_blank_ack) else $error("blank area not acknowledged");

  property p_blank_fail;
    @(posedge clk) disable iff (reset)
    q_r.st == BMQ_SCAN && scan_last && q_r.cmd != BMQ_CMD_SUM_UA && !blank_in
      |=> q_r.frm[0] == ((q_r.cmd == BMQ_CMD_BLK_UB) ? BMQ_RSP_BLK_UB : BMQ_RSP_BLK_UA)
          && q_r.frm[1] == BMQ_E_ERASE_INC && q_r.len == 3'h2 && q_r.err_flag;
  endproperty
  a_blank_fail: assert property (p_blank_fail) else $error("blank failure reply wrong");

  property p_inq_take;
    @(posedge clk) disable iff (reset)
    rx_valid && rx_ready && rx_data == BMQ_CMD_INQ && inq_ok
      |=> q_r.st == BMQ_SEND && q_r.frm[0] == BMQ_RSP_INQ && q_r.len == 3'h5;
  endproperty
  a_inq_take: assert property (p_inq_take) else $error("state inquiry not taken");

  property p_inq_err;
    @(posedge clk) disable iff (reset)
    rx_valid && rx_ready && rx_data == BMQ_CMD_INQ && inq_ok
      |=> q_r.frm[3] == {7'h00, $past(q_r.err_flag)};
  endproperty
  a_inq_err: assert property (p_inq_err) else $error("error flag byte wrong");

  property p_err_wins;
    @(posedge clk) disable iff (reset)
    err_event && err_clear |=> q_r.err_flag;
  endproperty
  a_err_wins: assert property (p_err_wins) else $error("error event lost on clear");

  property p_frame_zero;
    @(posedge clk) disable iff (reset)
    $rose(q_r.st == BMQ_SEND) && (q_r.len == 3'h7 || q_r.len == 3'h5) |-> frm_total == 8'h00;
  endproperty
  a_frame_zero: assert property (p_frame_zero) else $error("reply checksum nonzero");

  property p_key_lock;
    @(posedge clk) disable iff (reset)
    q_r.key_bad |=> pm_data == 8'h00 ##1 pm_data == 8'h00;
  endproperty
  a_key_lock: assert property (p_key_lock) else $error("locked read leaked data");

  c_sum:   cover property (@(posedge clk) disable iff (reset) push && q_r.cmd == BMQ_CMD_SUM_UA && q_r.idx == 3'h6);
  c_blank: cover property (@(posedge clk) disable iff (reset) push && q_r.frm[0] == BMQ_RSP_BLK_UA);
  c_inq:   cover property (@(posedge clk) disable iff (reset) push && q_r.cmd == BMQ_CMD_INQ && q_r.idx == 3'h4);
  c_full:  cover property (@(posedge clk) disable iff (reset) q_r.st == BMQ_SEND && !fifo_ready);
endmodule // bmq_core
`default_nettype wire

// ==== dv/bmq_host_model.sv ====
// Host programming tool model: sends command bytes, collects reply bytes
`timescale 1ns/10ps
`default_nettype none
module bmq_host_model (
  input  wire logic       clk,
  input  wire logic       hold,
  input  wire logic       slow,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data
);
  logic [7:0] got [$];
  logic       phase;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
    tx_ready = 1'b1;
    phase    = 1'b0;
  end

  // ----------------------------------------
  // Command side
  // ----------------------------------------
  // Request held until the taking edge; the data line is then inverted so a stale byte cannot pass
  task automatic send(input logic [7:0] cmd);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data  = cmd;
    while (rx_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data  = ~cmd;
  endtask

  // ----------------------------------------
  // Reply side
  // ----------------------------------------
  // Slow mode takes a byte only every other cycle
  always @(negedge clk) begin
    phase    <= ~phase;
    tx_ready <= !hold && (!slow || phase);
  end

  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule // bmq_host_model
`default_nettype wire

// ==== dv/tb_boot_mode_query_commands.sv ====
// Self-checking testbench of the boot-mode query command interpreter
`timescale 1ns/10ps
`default_nettype none
module tb_boot_mode_query_commands;
  import bmq_pkg::*;
  logic        clk, reset, rx_valid, rx_ready, tx_valid, tx_ready, flash_area;
  logic        err_event, err_clear, pm_mode, busy, hold, slow;
  logic [7:0]  rx_data, tx_data, flash_rdata, pm_data;
  logic [19:0] flash_addr, pm_addr;
  logic [2:0]  boot_state;
  logic [7:0]  ua_mem [64];
  logic [7:0]  ub_mem [8];
  logic [7:0]  st_tab [8];
  int          bad_count, checks, cycles;

  // Short areas keep every scan to a few cycles
  bmq_core #(.UA_SIZE(20'h00010), .UB_SIZE(20'h00008)) DUT (
    .clk(clk), .reset(reset), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .flash_addr(flash_addr),
    .flash_area(flash_area), .flash_rdata(flash_rdata), .boot_state(boot_state),
    .err_event(err_event), .err_clear(err_clear), .pm_mode(pm_mode), .pm_addr(pm_addr),
    .pm_data(pm_data), .busy(busy));

  bmq_host_model u_host (
    .clk(clk), .hold(hold), .slow(slow), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

  // Read-only flash model: the DUT never writes it, the scenarios load its bytes directly
  assign flash_rdata = flash_area ? ua_mem[flash_addr[5:0]] : ub_mem[flash_addr[2:0]];

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [7:0] ck(input logic [7:0] q [$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) s = s + q[i];
    return 8'h00 - s;
  endfunction

  task automatic cmp_reply(input string what, input logic [7:0] exp [$]);
    int k;
    k = 0;
    while (u_host.got.size() < exp.size() && k < 2000) begin
      @(negedge clk);
      k++;
    end
    repeat (4) @(negedge clk);
    check({what, " length"}, 8'(u_host.got.size()), 8'(exp.size()));
    foreach (exp[i]) check(what, u_host.got[i], exp[i]);
  endtask

  task automatic do_reset(input int n);
    @(negedge clk);
    reset = 1'b1;
    repeat (n) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check("busy in key check", {7'h00, busy}, 8'h01);
    check("ready in key check", {7'h00, rx_ready}, 8'h00);
    repeat (8) @(negedge clk);
  endtask

  task automatic pulse(input logic set, input logic clr);
    @(negedge clk);
    err_event = set;
    err_clear = clr;
    @(negedge clk);
    err_event = 1'b0;
    err_clear = 1'b0;
  endtask

  task automatic inquire(input logic [2:0] bs, input logic [7:0] flag);
    logic [7:0] e [$];
    boot_state = bs;
    e = {8'h5F, 8'h02, st_tab[bs], flag};
    e.push_back(ck(e));
    u_host.got.delete();
    u_host.send(BMQ_CMD_INQ);
    cmp_reply("inquiry", e);
  endtask

  task automatic refused(input logic [7:0] cmd);
    u_host.got.delete();
    u_host.send(cmd);
    cmp_reply("refused command", {cmd | 8'h80, 8'h80});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Sum reply then inquiry with the host stalled: twelve bytes overfill the buffer
  task automatic test_sum_fill();
    logic [31:0] s;
    logic [7:0]  e [$];
    s = 32'h0;
    for (int i = 0; i < 16; i++) begin
      ua_mem[i] = 8'(8'hF3 - 8'(i * 37));
      s = s + 32'(ua_mem[i]);
    end
    e = {8'h5B, 8'h04, s[31:24], s[23:16], s[15:8], s[7:0]};
    e.push_back(ck(e));
    boot_state = 3'h4;
    e = {e, 8'h5F, 8'h02, 8'h31, 8'h00, 8'h00 - (8'h5F + 8'h02 + 8'h31)};
    hold = 1'b1;
    u_host.got.delete();
    u_host.send(BMQ_CMD_SUM_UA);
    u_host.send(BMQ_CMD_INQ);
    repeat (20) @(negedge clk);
    check("busy with full buffer", {7'h00, busy}, 8'h01);
    check("reply pending", {7'h00, tx_valid}, 8'h01);
    hold = 1'b0;
    slow = 1'b1;
    cmp_reply("sum then inquiry", e);
    slow = 1'b0;
  endtask

  task automatic test_inquiry();
    pulse(1'b0, 1'b1);
    for (int b = 3; b < 8; b++) inquire(3'(b), 8'h00);
    for (int b = 0; b < 3; b++) begin
      boot_state = 3'(b);
      refused(BMQ_CMD_INQ);
    end
    inquire(3'h3, 8'h01);
    pulse(1'b0, 1'b1);
    inquire(3'h7, 8'h00);
    pulse(1'b1, 1'b1);
    inquire(3'h5, 8'h01);
    pulse(1'b0, 1'b1);
    pulse(1'b1, 1'b0);
    inquire(3'h6, 8'h01);
    refused(8'h41);
  endtask

  // Each area passes, then fails on its last byte
  task automatic test_blank();
    logic [7:0] e [$];
    for (int c = 0; c < 4; c++) begin
      foreach (ub_mem[i]) ub_mem[i] = 8'hFF;
      for (int i = 0; i < 16; i++) ua_mem[i] = 8'hFF;
      if (c[0] && c[1]) ua_mem[15] = 8'h7F;
      if (c[0] && !c[1]) ub_mem[7] = 8'hFE;
      if (!c[0]) e = {8'h06};
      else e = {c[1] ? 8'hCD : 8'hCC, 8'h52};
      u_host.got.delete();
      u_host.send(c[1] ? BMQ_CMD_BLK_UA : BMQ_CMD_BLK_UB);
      cmp_reply("blank check", e);
    end
  endtask

  task automatic test_pm_read();
    ua_mem[5] = 8'h3C;
    pm_addr   = 20'h00005;
    pm_mode   = 1'b1;
    @(negedge clk);
    check("open programmer read", pm_data, 8'h3C);
    ua_mem[61] = 8'h00;
    // Long hold, as a mode-change reset after flash work needs
    do_reset(1000);
    @(negedge clk);
    check("locked programmer read", pm_data, 8'h00);
    pm_mode = 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset      = 1'b1;
    err_event  = 1'b0;
    err_clear  = 1'b0;
    pm_mode    = 1'b0;
    pm_addr    = 20'h00000;
    boot_state = 3'h3;
    hold       = 1'b0;
    slow       = 1'b0;
    bad_count  = 0;
    checks     = 0;
    cycles     = 0;
    st_tab     = '{8'h11, 8'h12, 8'h13, 8'h1F, 8'h31, 8'h3F, 8'h4F, 8'h5F};
    foreach (ua_mem[i]) ua_mem[i] = 8'hFF;
    foreach (ub_mem[i]) ub_mem[i] = 8'hFF;
    do_reset(5);
    test_sum_fill();
    test_inquiry();
    test_blank();
    test_pm_read();
    wrap_up();
  end
endmodule // tb_boot_mode_query_commands
`default_nettype wire
